// >>> test/ebm_link_monitor.sv
// Concurrent checks on the link between memory block and user end
`timescale 1ns/1ps
`default_nettype none

module ebm_link_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Write side
    input wire logic wr_tick,
    input wire logic wr_ce,
    input wire logic wr_clr,
    input wire logic glb_clr,
    input wire logic cam_mode,
    input wire logic wr_strobe,
    input wire logic wr_dc,
    input wire logic wr_busy,
    // Read side
    input wire logic rd_tick,
    input wire logic rd_ce,
    input wire logic rd_clr,
    input wire logic fetch_strobe,
    input wire ebm_pkg::ebm_word_t rd_data,
    input wire logic match_flag,
    input wire ebm_pkg::ebm_addr_t match_addr,
    input wire ebm_pkg::ebm_lines_t match_lines,
    input wire logic lines_upper
);
    import ebm_pkg::*;
    logic wr_take;
    logic rd_take;
    logic rd_free;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // Edges at which each side accepts a strobe; clears block both
    assign wr_take = wr_tick & wr_ce & ~wr_clr & ~glb_clr & wr_strobe
        & ~wr_busy;
    assign rd_take = rd_tick & rd_ce & ~rd_clr & ~glb_clr & fetch_strobe;
    assign rd_free = rd_tick & rd_ce & ~rd_clr & ~glb_clr & ~fetch_strobe;

    // Tick spacing of 2 on the write side and 3 on the read side assumed
    a_write_two_ticks: assert property (
        wr_take && cam_mode && !wr_dc |=>
        wr_busy ##1 (wr_busy && wr_tick) ##1 !wr_busy)
        else $error("search write not done in two write cycles");
    a_masked_three_ticks: assert property (
        wr_take && cam_mode && wr_dc |=> wr_busy ##1 (wr_busy && wr_tick)
        ##1 wr_busy ##1 (wr_busy && wr_tick) ##1 !wr_busy)
        else $error("masked write not done in three write cycles");
    a_ram_write_free: assert property (
        wr_take && !cam_mode |=> !wr_busy)
        else $error("plain write left the write side busy");
    a_busy_write_clock: assert property (
        !wr_tick && !wr_clr && !glb_clr |=> $stable(wr_busy))
        else $error("busy moved without a write tick");
    a_rd_data_hold: assert property (
        !rd_tick && !rd_clr && !glb_clr |=> $stable(rd_data))
        else $error("read data moved without a read tick");
    a_match_hold: assert property (
        !rd_tick && !rd_clr && !glb_clr |=> $stable(match_flag)
        && $stable(match_addr) && $stable(lines_upper))
        else $error("search result moved without a read tick");
    a_search_low_half: assert property (
        rd_take && cam_mode |=> !lines_upper
        && (match_flag || match_lines == 16'h0000))
        else $error("search result bad in first cycle");
    a_enc_lowest_hit: assert property (
        rd_take && cam_mode |=> match_lines == 16'h0000
        || (!match_addr[4] && match_lines[match_addr[3:0]]
        && (match_lines & ((16'h0001 << match_addr[3:0]) - 16'h0001))
        == 16'h0000))
        else $error("encoded address is not the lowest hit line");
    a_upper_half_next: assert property (
        rd_take && cam_mode ##3 rd_free |=> lines_upper)
        else $error("upper half not shown on the next read tick");
endmodule : ebm_link_monitor

`default_nettype wire

// >>> test/testbench.sv
// Bench joining the memory block to its user end
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import ebm_pkg::*;
    // Stimulus of the user side
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cam_mode = 1'b0;
    logic enc_sel = 1'b0;
    logic clear_req = 1'b0;
    logic wr_req = 1'b0;
    logic wr_dc = 1'b0;
    logic rd_req = 1'b0;
    ebm_addr_t wr_addr = 5'h00;
    ebm_addr_t rd_addr = 5'h00;
    ebm_word_t wr_data = 32'h0000_0000;
    ebm_word_t wr_care = 32'hFFFF_FFFF;
    ebm_word_t search_word = 32'h0000_0000;
    // Answers of the user end
    logic req_ready;
    logic wr_done;
    logic wr_refused;
    logic rd_valid;
    logic match;
    ebm_word_t rd_data;
    ebm_addr_t match_addr;
    ebm_hits_t match_lines;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    localparam ebm_word_t key = 32'hC0DE_0042;
    localparam ebm_word_t ones = 32'hFFFF_FFFF;

    ebm_if i_ebm_if ();
    // write side on a dedicated tick line
    ebm_memory_block #(.WR_SRC(4)) i_ebm_memory_block (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .lnk(i_ebm_if.dev));
    ebm_user_end #(.WR_DIV(2), .RD_DIV(3)) i_ebm_user_end (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .cam_mode(cam_mode),
        .enc_sel(enc_sel), .clear_req(clear_req), .wr_req(wr_req),
        .wr_dc(wr_dc), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_care(wr_care), .rd_req(rd_req), .rd_addr(rd_addr),
        .search_word(search_word), .req_ready(req_ready),
        .wr_done(wr_done), .wr_refused(wr_refused), .rd_valid(rd_valid),
        .rd_data(rd_data), .match(match), .match_addr(match_addr),
        .match_lines(match_lines), .lnk(i_ebm_if.usr));
    ebm_link_monitor i_ebm_link_monitor (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .wr_tick(i_ebm_if.wr_tick),
        .wr_ce(i_ebm_if.wr_ce), .wr_clr(i_ebm_if.wr_clr),
        .glb_clr(i_ebm_if.glb_clr), .cam_mode(i_ebm_if.cam_mode),
        .wr_strobe(i_ebm_if.wr_strobe), .wr_dc(i_ebm_if.wr_dc),
        .wr_busy(i_ebm_if.wr_busy), .rd_tick(i_ebm_if.rd_tick),
        .rd_ce(i_ebm_if.rd_ce), .rd_clr(i_ebm_if.rd_clr),
        .fetch_strobe(i_ebm_if.fetch_strobe), .rd_data(i_ebm_if.rd_data),
        .match_flag(i_ebm_if.match_flag), .match_addr(i_ebm_if.match_addr),
        .match_lines(i_ebm_if.match_lines),
        .lines_upper(i_ebm_if.lines_upper));

    // Clock of 20 ns
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // A hang ends the run as a mismatch
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            $display("[FAIL] %0t run did not finish", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_addr(input ebm_addr_t got, input ebm_addr_t exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t address %h expected %h", $time, got, exp);
        end
    endtask : chk_addr

    task automatic chk_word(input ebm_word_t got, input ebm_word_t exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    // Reset for six cycles, which also reloads the contents
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : do_reset

    // Hold a request until an edge samples req_ready high
    task automatic wait_take();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        #1;
    endtask : wait_take

    // Answers are one-cycle pulses, so look after every edge
    task automatic wait_answer();
        int n;
        n = 0;
        while (wr_done !== 1'b1 && wr_refused !== 1'b1 && rd_valid !== 1'b1
            && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask : wait_answer

    task automatic do_write(input logic dc, input ebm_addr_t a,
        input ebm_word_t d, input ebm_word_t care, input logic refused);
        wr_dc = dc;
        wr_addr = a;
        wr_data = d;
        wr_care = care;
        wr_req = 1'b1;
        wait_take();
        wr_req = 1'b0;
        wait_answer();
        chk_bit(wr_refused, refused);
        chk_bit(wr_done, ~refused);
    endtask : do_write

    task automatic do_read(input ebm_addr_t a, input ebm_word_t w);
        rd_addr = a;
        search_word = w;
        rd_req = 1'b1;
        wait_take();
        rd_req = 1'b0;
        wait_answer();
        chk_bit(rd_valid, 1'b1);
    endtask : do_read

    // Plain memory first, then the search memory after a second reset
    initial begin
        do_reset();
        do_read(5'h03, key);
        chk_word(rd_data, 32'h0000_0000);
        do_write(1'b0, 5'h03, 32'hA5C3_0F1E, ones, 1'b0);
        do_write(1'b0, 5'h1F, 32'h1234_5678, ones, 1'b0);
        do_read(5'h03, key);
        chk_word(rd_data, 32'hA5C3_0F1E);
        do_read(5'h1F, key);
        chk_word(rd_data, 32'h1234_5678);
        do_reset();
        cam_mode = 1'b1;
        enc_sel = 1'b1;
        do_read(5'h00, 32'h0000_0000);
        chk_addr(match_addr, 5'h00);
        chk_word(match_lines, ones);
        do_read(5'h00, key);
        chk_bit(match, 1'b0);
        chk_word(match_lines, 32'h0000_0000);
        do_write(1'b0, 5'h0C, key, ones, 1'b0);
        do_read(5'h00, key);
        chk_bit(match, 1'b1);
        chk_addr(match_addr, 5'h0C);
        chk_word(match_lines, 32'h0000_1000);
        do_write(1'b0, 5'h1F, key, ones, 1'b1);
        enc_sel = 1'b0;
        do_write(1'b0, 5'h1F, key, ones, 1'b0);
        do_read(5'h00, key);
        chk_addr(match_addr, 5'h0C);
        chk_word(match_lines, 32'h8000_1000);
        do_write(1'b1, 5'h05, 32'h7E81_1111, 32'hFFFF_0000, 1'b0);
        do_read(5'h00, 32'h7E81_ABCD);
        chk_bit(match, 1'b1);
        chk_word(match_lines, 32'h0000_0020);
        do_read(5'h00, 32'h7E80_1111);
        chk_bit(match, 1'b0);
        // A clear keeps the stored entries
        clear_req = 1'b1;
        @(posedge ref_clk);
        #1 clear_req = 1'b0;
        do_read(5'h00, key);
        chk_word(match_lines, 32'h8000_1000);
        finish_test();
    end
endmodule : testbench

`default_nettype wire

// >>> verilog/ebm_defines.svh
// Constants of the embedded memory block and its user logic end
`ifndef EBM_DEFINES_SVH
`define EBM_DEFINES_SVH

// Geometry of the search memory and count of dedicated tick lines
`define EBM_WORDS 32
`define EBM_WIDTH 32
`define EBM_AW 5
`define EBM_LINES 16
`define EBM_DED_CLKS 4

// Contents loaded at configuration
`define EBM_INIT_DATA 32'h0000_0000

// Bit positions of the register option vector
`define EBM_RS_DIN 0
`define EBM_RS_DOUT 1
`define EBM_RS_RADDR 2
`define EBM_RS_WADDR 3
`define EBM_RS_WE 4
`define EBM_RS_RE 5
`define EBM_REG_SEL_DEF 6'h00

// Tick dividers of the user end
`define EBM_DIV_W 8
`define EBM_WR_DIV_DEF 2
`define EBM_RD_DIV_DEF 3

`endif

// >>> verilog/ebm_if.sv
// Link between the memory block and its user logic
`timescale 1ns/1ps
`default_nettype none

interface ebm_if;
    import ebm_pkg::*;
    logic wr_tick;
    logic rd_tick;
    ebm_ded_t ded_tick;
    logic wr_ce;
    logic rd_ce;
    logic wr_clr;
    logic rd_clr;
    logic glb_clr;
    logic cam_mode;
    logic enc_sel;
    logic wr_strobe;
    logic wr_dc;
    ebm_addr_t wr_addr;
    ebm_word_t wr_data;
    ebm_word_t wr_care;
    logic fetch_strobe;
    ebm_addr_t rd_addr;
    ebm_word_t search_word;
    ebm_word_t rd_data;
    logic match_flag;
    ebm_addr_t match_addr;
    ebm_lines_t match_lines;
    logic lines_upper;
    logic wr_busy;

    modport dev (
        input wr_tick, rd_tick, ded_tick, wr_ce, rd_ce, wr_clr, rd_clr,
        input glb_clr, cam_mode, enc_sel, wr_strobe, wr_dc, wr_addr,
        input wr_data, wr_care, fetch_strobe, rd_addr, search_word,
        output rd_data, match_flag, match_addr, match_lines, lines_upper,
        output wr_busy
    );

    modport usr (
        output wr_tick, rd_tick, ded_tick, wr_ce, rd_ce, wr_clr, rd_clr,
        output glb_clr, cam_mode, enc_sel, wr_strobe, wr_dc, wr_addr,
        output wr_data, wr_care, fetch_strobe, rd_addr, search_word,
        input rd_data, match_flag, match_addr, match_lines, lines_upper,
        input wr_busy
    );
endinterface : ebm_if

`default_nettype wire

// >>> verilog/ebm_memory_block.sv
// Embedded memory block: RAM with two rates or 32x32 search memory
`timescale 1ns/1ps
`default_nettype none
`include "ebm_defines.svh"

module ebm_memory_block #(
    // Optional register per signal, one bit each; the data-in bit also covers the mask and wr_dc
    parameter logic [5:0] REG_SEL = `EBM_REG_SEL_DEF,
    // Tick source per side: 0 local, 1 to 4 a dedicated tick line
    parameter int unsigned WR_SRC = 0,
    parameter int unsigned RD_SRC = 0
) (
    // Clock and chip-wide reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link to user logic
    ebm_if.dev lnk
);
    import ebm_pkg::*;

    // Select a side's tick from the local line or a dedicated one
    function automatic logic pick_tick(input logic loc, input ebm_ded_t ded,
                                       input int unsigned src);
        logic t;
        t = loc;
        for (int i = 0; i < `EBM_DED_CLKS; i++) begin
            if (src == i + 1) begin
                t = ded[i];
            end
        end
        return t;
    endfunction : pick_tick

    // Lowest matching entry wins when several hit
    function automatic ebm_addr_t first_hit(input ebm_hits_t h);
        ebm_addr_t a;
        a = '0;
        for (int i = `EBM_WORDS - 1; i >= 0; i--) begin
            if (h[i]) begin
                a = ebm_addr_t'(i);
            end
        end
        return a;
    endfunction : first_hit

    logic wr_tk, rd_tk;
    logic wr_en, rd_en;
    logic wr_kill, rd_kill;

    assign wr_tk = pick_tick(lnk.wr_tick, lnk.ded_tick, WR_SRC);
    assign rd_tk = pick_tick(lnk.rd_tick, lnk.ded_tick, RD_SRC);
    assign wr_en = wr_tk & lnk.wr_ce;
    assign rd_en = rd_tk & lnk.rd_ce;
    assign wr_kill = sys_rst | lnk.glb_clr | lnk.wr_clr;
    assign rd_kill = sys_rst | lnk.glb_clr | lnk.rd_clr;

    // Write-side option registers
    ebm_word_t din_reg;
    ebm_word_t care_reg;
    logic dc_reg;
    ebm_addr_t wa_reg;
    logic we_reg;
    ebm_word_t din;
    ebm_word_t care;
    logic dc;
    ebm_addr_t wa;
    logic we;

    always_ff @(posedge ref_clk) begin
        if (wr_kill) begin
            din_reg <= '0;
            care_reg <= '0;
            dc_reg <= 1'b0;
            wa_reg <= '0;
            we_reg <= 1'b0;
        end else if (wr_en) begin
            din_reg <= lnk.wr_data;
            care_reg <= lnk.wr_care;
            dc_reg <= lnk.wr_dc;
            wa_reg <= lnk.wr_addr;
            we_reg <= lnk.wr_strobe;
        end
    end

    assign din = REG_SEL[`EBM_RS_DIN] ? din_reg : lnk.wr_data;
    assign care = REG_SEL[`EBM_RS_DIN] ? care_reg : lnk.wr_care;
    assign dc = REG_SEL[`EBM_RS_DIN] ? dc_reg : lnk.wr_dc;
    assign wa = REG_SEL[`EBM_RS_WADDR] ? wa_reg : lnk.wr_addr;
    assign we = REG_SEL[`EBM_RS_WE] ? we_reg : lnk.wr_strobe;

    // Search memory write sequencer
    ebm_wr_state_t wr_state_reg;
    ebm_wr_state_t wr_state_next;
    ebm_addr_t lat_addr_reg;
    ebm_word_t lat_data_reg;
    ebm_word_t lat_care_reg;
    logic lat_dc_reg;
    logic wr_busy_reg;

    always_comb begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            EBM_WR_IDLE: begin
                if (lnk.cam_mode && we) begin
                    wr_state_next = EBM_WR_DATA;
                end
            end
            EBM_WR_DATA: begin
                wr_state_next = lat_dc_reg ? EBM_WR_MASK : EBM_WR_IDLE;
            end
            default: wr_state_next = EBM_WR_IDLE;
        endcase
    end

    // State and busy advance only on the write tick
    always_ff @(posedge ref_clk) begin
        if (wr_kill) begin
            wr_state_reg <= EBM_WR_IDLE;
            wr_busy_reg <= 1'b0;
        end else if (wr_en) begin
            wr_state_reg <= wr_state_next;
            wr_busy_reg <= (wr_state_next != EBM_WR_IDLE);
        end
    end

    // Latch the entry so the fabric may move on after the first cycle
    always_ff @(posedge ref_clk) begin
        if (wr_kill) begin
            lat_addr_reg <= '0;
            lat_data_reg <= '0;
            lat_care_reg <= '0;
            lat_dc_reg <= 1'b0;
        end else if (wr_en && wr_state_reg == EBM_WR_IDLE && we) begin
            lat_addr_reg <= wa;
            lat_data_reg <= din;
            lat_care_reg <= care;
            lat_dc_reg <= dc;
        end
    end

    // 32 entries of 32 bits; mask 1 = compared
    ebm_word_t data_mem [0:`EBM_WORDS-1];
    ebm_word_t care_mem [0:`EBM_WORDS-1];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < `EBM_WORDS; i++) begin
                data_mem[i] <= `EBM_INIT_DATA;
                care_mem[i] <= '1;
            end
        end else if (wr_en && !wr_kill) begin
            if (!lnk.cam_mode && we) begin
                data_mem[wa] <= din;
                care_mem[wa] <= '1;
            end else if (wr_state_reg == EBM_WR_DATA) begin
                data_mem[lat_addr_reg] <= lat_data_reg;
                care_mem[lat_addr_reg] <= '1;
            end else if (wr_state_reg == EBM_WR_MASK) begin
                care_mem[lat_addr_reg] <= lat_care_reg;
            end
        end
    end

    ebm_hits_t hits;
    always_comb begin
        hits = '0;
        for (int i = 0; i < `EBM_WORDS; i++) begin
            hits[i] = ((data_mem[i] ^ lnk.search_word) & care_mem[i]) == '0;
        end
    end

    // Read-side option registers
    ebm_addr_t ra_reg;
    logic fs_reg;
    ebm_addr_t ra;
    logic fs;

    always_ff @(posedge ref_clk) begin
        if (rd_kill) begin
            ra_reg <= '0;
            fs_reg <= 1'b0;
        end else if (rd_en) begin
            ra_reg <= lnk.rd_addr;
            fs_reg <= lnk.fetch_strobe;
        end
    end

    assign ra = REG_SEL[`EBM_RS_RADDR] ? ra_reg : lnk.rd_addr;
    assign fs = REG_SEL[`EBM_RS_RE] ? fs_reg : lnk.fetch_strobe;

    // RAM read path; the option adds one read tick of latency
    ebm_word_t q_pipe_reg;
    ebm_word_t rd_data_reg;
    always_ff @(posedge ref_clk) begin
        if (rd_kill) begin
            q_pipe_reg <= '0;
            rd_data_reg <= '0;
        end else if (rd_en) begin
            if (fs && !lnk.cam_mode) begin
                q_pipe_reg <= data_mem[ra];
            end
            if (REG_SEL[`EBM_RS_DOUT]) begin
                rd_data_reg <= q_pipe_reg;
            end else if (fs && !lnk.cam_mode) begin
                rd_data_reg <= data_mem[ra];
            end
        end
    end

    // Search results
    logic match_reg;
    ebm_addr_t match_addr_reg;
    ebm_lines_t lines_reg;
    ebm_lines_t upper_hold_reg;
    logic lines_upper_reg;
    logic upper_pend_reg;

    // Search result registers, read clock side
    always_ff @(posedge ref_clk) begin
        if (rd_kill) begin
            match_reg <= 1'b0;
            match_addr_reg <= '0;
            lines_reg <= '0;
            upper_hold_reg <= '0;
            lines_upper_reg <= 1'b0;
            upper_pend_reg <= 1'b0;
        end else if (rd_en) begin
            if (fs && lnk.cam_mode) begin
                match_reg <= |hits;
                match_addr_reg <= first_hit(hits);
                lines_reg <= hits[`EBM_LINES-1:0];
                upper_hold_reg <= hits[`EBM_WORDS-1:`EBM_LINES];
                lines_upper_reg <= 1'b0;
                upper_pend_reg <= 1'b1;
            end else if (upper_pend_reg) begin
                lines_reg <= upper_hold_reg;
                lines_upper_reg <= 1'b1;
                upper_pend_reg <= 1'b0;
            end
        end
    end

    // Outputs straight from their registers
    assign lnk.rd_data = rd_data_reg;
    assign lnk.match_flag = match_reg;
    assign lnk.match_addr = match_addr_reg;
    assign lnk.match_lines = lines_reg;
    assign lnk.lines_upper = lines_upper_reg;
    assign lnk.wr_busy = wr_busy_reg;
endmodule : ebm_memory_block
`default_nettype wire

// >>> verilog/ebm_pkg.sv
// Types shared by both ends of the embedded memory block
`default_nettype none
`include "ebm_defines.svh"

package ebm_pkg;
    typedef logic [`EBM_WIDTH-1:0] ebm_word_t;
    typedef logic [`EBM_AW-1:0] ebm_addr_t;
    typedef logic [`EBM_WORDS-1:0] ebm_hits_t;
    typedef logic [`EBM_LINES-1:0] ebm_lines_t;
    typedef logic [`EBM_DED_CLKS-1:0] ebm_ded_t;

    // Write sequencer of the search memory
    typedef enum logic [1:0] {
        EBM_WR_IDLE,
        EBM_WR_DATA,
        EBM_WR_MASK
    } ebm_wr_state_t;

    // Request sequencer of the user end
    typedef enum logic [3:0] {
        EBM_U_IDLE,
        EBM_U_CHK,
        EBM_U_CHKW,
        EBM_U_WISS,
        EBM_U_WBUSY,
        EBM_U_RISS,
        EBM_U_RLO,
        EBM_U_RHI,
        EBM_U_RHIC
    } ebm_user_state_t;
endpackage : ebm_pkg

`default_nettype wire

// >>> verilog/ebm_user_end.sv
// User logic end: drives ticks, strobes and clears of the memory block
`timescale 1ns/1ps
`default_nettype none
`include "ebm_defines.svh"

module ebm_user_end #(
    // Reference cycles per write tick and per read tick
    parameter int unsigned WR_DIV = `EBM_WR_DIV_DEF,
    parameter int unsigned RD_DIV = `EBM_RD_DIV_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Mode and clear
    input wire logic cam_mode,
    input wire logic enc_sel,
    input wire logic clear_req,
    // Write request
    input wire logic wr_req,
    input wire logic wr_dc,
    input wire ebm_pkg::ebm_addr_t wr_addr,
    input wire ebm_pkg::ebm_word_t wr_data,
    input wire ebm_pkg::ebm_word_t wr_care,
    // Read or search request
    input wire logic rd_req,
    input wire ebm_pkg::ebm_addr_t rd_addr,
    input wire ebm_pkg::ebm_word_t search_word,
    // Answers
    output logic req_ready,
    output logic wr_done,
    output logic wr_refused,
    output logic rd_valid,
    output ebm_pkg::ebm_word_t rd_data,
    output logic match,
    output ebm_pkg::ebm_addr_t match_addr,
    output ebm_pkg::ebm_hits_t match_lines,
    // Link to the memory block
    ebm_if.usr lnk
);
    import ebm_pkg::*;

    // Wrapping divider count
    function automatic logic [`EBM_DIV_W-1:0] div_next(
        input logic [`EBM_DIV_W-1:0] c, input int unsigned d);
        div_next = (32'(c) + 1 >= d) ? '0 : c + 1'b1;
    endfunction : div_next

    logic [`EBM_DIV_W-1:0] wcnt_reg;
    logic [`EBM_DIV_W-1:0] rcnt_reg;
    logic wtick_reg;
    logic rtick_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wcnt_reg <= '0;
            rcnt_reg <= '0;
            wtick_reg <= 1'b0;
            rtick_reg <= 1'b0;
        end else begin
            wcnt_reg <= div_next(wcnt_reg, WR_DIV);
            rcnt_reg <= div_next(rcnt_reg, RD_DIV);
            wtick_reg <= (div_next(wcnt_reg, WR_DIV) == '0);
            rtick_reg <= (div_next(rcnt_reg, RD_DIV) == '0);
        end
    end

    ebm_user_state_t st_reg;
    ebm_user_state_t st_next;
    logic dup_guard;

    assign dup_guard = cam_mode && enc_sel && !wr_dc;

    // Request sequencer; one request at a time, write first
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            EBM_U_IDLE: begin
                // Only take what the operand latch takes as well
                if (req_ready && wr_req) begin
                    st_next = dup_guard ? EBM_U_CHK : EBM_U_WISS;
                end else if (req_ready && rd_req) begin
                    st_next = EBM_U_RISS;
                end
            end
            EBM_U_CHK: st_next = rtick_reg ? EBM_U_CHKW : st_reg;
            EBM_U_CHKW: st_next = lnk.match_flag ? EBM_U_IDLE : EBM_U_WISS;
            EBM_U_WISS: st_next = wtick_reg ? EBM_U_WBUSY : st_reg;
            EBM_U_WBUSY: st_next = lnk.wr_busy ? st_reg : EBM_U_IDLE;
            EBM_U_RISS: st_next = rtick_reg ? EBM_U_RLO : st_reg;
            EBM_U_RLO: st_next = lnk.cam_mode ? EBM_U_RHI : EBM_U_IDLE;
            EBM_U_RHI: st_next = rtick_reg ? EBM_U_RHIC : st_reg;
            default: st_next = EBM_U_IDLE;
        endcase
        if (clear_req) begin
            st_next = EBM_U_IDLE;
        end
    end

    // State and link controls, all registered
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_reg <= EBM_U_IDLE;
            req_ready <= 1'b0;
            lnk.wr_strobe <= 1'b0;
            lnk.fetch_strobe <= 1'b0;
            lnk.glb_clr <= 1'b1;
            lnk.cam_mode <= 1'b0;
            lnk.enc_sel <= 1'b0;
        end else begin
            st_reg <= st_next;
            req_ready <= (st_next == EBM_U_IDLE) && !clear_req;
            lnk.wr_strobe <= (st_next == EBM_U_WISS);
            lnk.fetch_strobe <= (st_next == EBM_U_CHK) ||
                                (st_next == EBM_U_RISS);
            lnk.glb_clr <= clear_req;
            lnk.cam_mode <= cam_mode;
            lnk.enc_sel <= enc_sel;
        end
    end

    // Request operands held from acceptance until done
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lnk.wr_addr <= '0;
            lnk.wr_data <= '0;
            lnk.wr_care <= '1;
            lnk.wr_dc <= 1'b0;
            lnk.rd_addr <= '0;
            lnk.search_word <= '0;
        end else if (st_reg == EBM_U_IDLE && req_ready) begin
            if (wr_req) begin
                lnk.wr_addr <= wr_addr;
                lnk.wr_data <= wr_data;
                lnk.wr_care <= wr_dc ? wr_care : '1;
                lnk.wr_dc <= wr_dc;
                lnk.search_word <= wr_data;
            end else if (rd_req) begin
                lnk.rd_addr <= rd_addr;
                lnk.search_word <= search_word;
            end
        end
    end

    // Answers, one-cycle pulses and held results
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_done <= 1'b0;
            wr_refused <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            match <= 1'b0;
            match_addr <= '0;
            match_lines <= '0;
        end else begin
            wr_done <= (st_reg == EBM_U_WBUSY) && !lnk.wr_busy;
            wr_refused <= (st_reg == EBM_U_CHKW) && lnk.match_flag;
            rd_valid <= ((st_reg == EBM_U_RLO) && !lnk.cam_mode) ||
                        (st_reg == EBM_U_RHIC);
            if (st_reg == EBM_U_RLO) begin
                rd_data <= lnk.rd_data;
                match <= lnk.match_flag;
                match_addr <= lnk.match_addr;
                match_lines[`EBM_LINES-1:0] <= lnk.match_lines;
            end
            if (st_reg == EBM_U_RHIC) begin
                match_lines[`EBM_WORDS-1:`EBM_LINES] <= lnk.match_lines;
            end
        end
    end

    // Ticks and enables; per-side clears unused, global clear serves both
    assign lnk.wr_tick = wtick_reg;
    assign lnk.rd_tick = rtick_reg;
    assign lnk.ded_tick = {`EBM_DED_CLKS{wtick_reg}};
    assign lnk.wr_ce = 1'b1;
    assign lnk.rd_ce = lnk.wr_ce;
    assign lnk.wr_clr = 1'b0;
    assign lnk.rd_clr = 1'b0;
endmodule : ebm_user_end

`default_nettype wire
